// ===== port9_defs.svh
// Purpose: Offsets, field masks and reset values of the port 9 mux block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Only the low 16 bits of each register are used.
`ifndef PORT9_DEFS_SVH
`define PORT9_DEFS_SVH

`define P9_OFS_LATCH    12'h000
`define P9_OFS_DIR      12'h004
`define P9_OFS_ALT      12'h008
`define P9_OFS_FSEL     12'h00C
`define P9_OFS_FEXT     12'h010
`define P9_OFS_PULLUP   12'h014
`define P9_OFS_LEVEL    12'h018

`define P9_RST_REG      16'h0000
`define P9_FEXT_MASK    16'h20FF

`endif

// ===== port9_pkg.sv
// Purpose: Types shared by the port 9 mux block and its users.
// Assumes: Nothing beyond the defs header.
// Notes:   Peripheral signals travel as packed structs.
package port9_pkg;

  // Signals that peripherals drive toward the pins.
  typedef struct packed {
    logic programmable_clock_out;
    logic csi2_sck_out;
    logic csi2_sck_oe;
    logic csi2_so;
    logic csi1_sck_out;
    logic csi1_sck_oe;
    logic csi1_so;
    logic timer_p2_ch0_compare_out;
    logic timer_p2_ch1_compare_out;
    logic timer_q1_ch0_compare_out;
    logic timer_q1_ch1_compare_out;
    logic timer_q1_ch2_compare_out;
    logic timer_q1_ch3_compare_out;
    logic uart1_transmit_out;
  } periph_out_t;

  // Pin levels handed to peripheral inputs.
  typedef struct packed {
    logic ext_interrupt_in_4;
    logic ext_interrupt_in_5;
    logic ext_interrupt_in_6;
    logic csi2_sck_in;
    logic csi2_si;
    logic csi1_sck_in;
    logic csi1_si;
    logic timer_p2_ch0_capture_in;
    logic timer_p2_ch1_capture_in;
    logic timer_q1_ch0_capture_in;
    logic timer_q1_ch1_capture_in;
    logic timer_q1_ch2_capture_in;
    logic timer_q1_ch3_capture_in;
    logic key_return_in_6;
    logic key_return_in_7;
    logic uart1_receive_in;
  } periph_in_t;

  typedef logic [15:0] word16_t;

endpackage

// ===== port9_alt_function_select.sv
// Purpose: Port 9 pin function multiplexer with APB register file.
// Assumes: Pins and peripheral signals are synchronous to clk_sys.
// Notes:   Prohibited select codes leave the pin undriven.
`timescale 1ns/100ps
`include "port9_defs.svh"

module port9_alt_function_select
  import port9_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pins
  input  wire logic [15:0] pin_in,
  output logic [15:0]      pin_out,
  output logic [15:0]      pin_oe,
  output logic [15:0]      pin_pullup_en,
  // Peripherals
  input  wire periph_out_t periph_out,
  output periph_in_t       periph_in
);

  word16_t port9_output_latch;
  word16_t port9_output_enable;
  word16_t port9_alternate_enable;
  word16_t port9_function_select;
  word16_t port9_function_select_extension;
  word16_t port9_pullup_enable;

  word16_t    next_pin_out;
  word16_t    next_pin_oe;
  periph_in_t next_periph_in;
  logic [31:0] next_rdata;
  logic        next_err;

  logic access;
  logic wr_en;
  logic rd_hit;

  // Merges byte lanes of a write into a 16-bit register.
  function automatic word16_t lane_merge(input word16_t old_val,
                                         input logic [31:0] wdata,
                                         input logic [3:0] strb);
    word16_t res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // Control code of one pin: extension bit above select bit.
  function automatic logic [1:0] code_of(input int unsigned n);
    return {port9_function_select_extension[n], port9_function_select[n]};
  endfunction

  assign access = psel & penable & ~pready;
  assign wr_en  = access & pwrite & ~next_err;
  assign rd_hit = access & ~pwrite;

  // Address decode and read data.
  always_comb begin
    next_err   = 1'b0;
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      `P9_OFS_LATCH:  next_rdata[15:0] = port9_output_latch;
      `P9_OFS_DIR:    next_rdata[15:0] = port9_output_enable;
      `P9_OFS_ALT:    next_rdata[15:0] = port9_alternate_enable;
      `P9_OFS_FSEL:   next_rdata[15:0] = port9_function_select;
      `P9_OFS_FEXT:   next_rdata[15:0] = port9_function_select_extension;
      `P9_OFS_PULLUP: next_rdata[15:0] = port9_pullup_enable;
      `P9_OFS_LEVEL:  next_rdata[15:0] = pin_in;
      default:        next_err = 1'b1;
    endcase
  end

  // APB handshake: one wait state, answer registered.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= access;
      pslverr <= access & next_err;
      prdata  <= rd_hit ? next_rdata : 32'h0000_0000;
    end
  end

  // Port latch and direction registers.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port9_output_latch  <= `P9_RST_REG;
      port9_output_enable <= `P9_RST_REG;
    end else if (clk_en && wr_en) begin
      if (paddr == `P9_OFS_LATCH) begin
        port9_output_latch <= lane_merge(port9_output_latch, pwdata, pstrb);
      end
      if (paddr == `P9_OFS_DIR) begin
        port9_output_enable <= lane_merge(port9_output_enable, pwdata, pstrb);
      end
    end
  end

  // Mode registers; extension bits without a function stay zero.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port9_alternate_enable          <= `P9_RST_REG;
      port9_function_select           <= `P9_RST_REG;
      port9_function_select_extension <= `P9_RST_REG;
    end else if (clk_en && wr_en) begin
      if (paddr == `P9_OFS_ALT) begin
        port9_alternate_enable <= lane_merge(port9_alternate_enable, pwdata, pstrb);
      end
      if (paddr == `P9_OFS_FSEL) begin
        port9_function_select <= lane_merge(port9_function_select, pwdata, pstrb);
      end
      if (paddr == `P9_OFS_FEXT) begin
        port9_function_select_extension <=
          lane_merge(port9_function_select_extension, pwdata, pstrb) & `P9_FEXT_MASK;
      end
    end
  end

  // Pull-up register, each byte half written alone.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port9_pullup_enable <= `P9_RST_REG;
    end else if (clk_en && wr_en && paddr == `P9_OFS_PULLUP) begin
      port9_pullup_enable <= lane_merge(port9_pullup_enable, pwdata, pstrb);
    end
  end

  // Pin output mux.
  always_comb begin
    next_pin_out = port9_output_latch;
    next_pin_oe  = port9_output_enable;
    for (int n = 0; n < 16; n++) begin
      if (port9_alternate_enable[n]) begin
        next_pin_out[n] = 1'b0;
        next_pin_oe[n]  = 1'b0;
      end
    end
    if (port9_alternate_enable[13] && code_of(13) == 2'b10) begin
      next_pin_out[13] = periph_out.programmable_clock_out;
      next_pin_oe[13]  = 1'b1;
    end
    if (port9_alternate_enable[12] && port9_function_select[12]) begin
      next_pin_out[12] = periph_out.csi2_sck_out;
      next_pin_oe[12]  = periph_out.csi2_sck_oe;
    end
    if (port9_alternate_enable[11] && port9_function_select[11]) begin
      next_pin_out[11] = periph_out.csi2_so;
      next_pin_oe[11]  = 1'b1;
    end
    if (port9_alternate_enable[9] && port9_function_select[9]) begin
      next_pin_out[9] = periph_out.csi1_sck_out;
      next_pin_oe[9]  = periph_out.csi1_sck_oe;
    end
    if (port9_alternate_enable[8] && port9_function_select[8]) begin
      next_pin_out[8] = periph_out.csi1_so;
      next_pin_oe[8]  = 1'b1;
    end
    if (port9_alternate_enable[7] && code_of(7) == 2'b11) begin
      next_pin_out[7] = periph_out.timer_p2_ch0_compare_out;
      next_pin_oe[7]  = 1'b1;
    end
    if (port9_alternate_enable[6] && code_of(6) == 2'b11) begin
      next_pin_out[6] = periph_out.timer_p2_ch1_compare_out;
      next_pin_oe[6]  = 1'b1;
    end
    if (port9_alternate_enable[5] && code_of(5) == 2'b10) begin
      next_pin_out[5] = periph_out.timer_q1_ch0_compare_out;
      next_pin_oe[5]  = 1'b1;
    end
    if (port9_alternate_enable[4] && code_of(4) == 2'b10) begin
      next_pin_out[4] = periph_out.timer_q1_ch3_compare_out;
      next_pin_oe[4]  = 1'b1;
    end
    if (port9_alternate_enable[3] && code_of(3) == 2'b10) begin
      next_pin_out[3] = periph_out.timer_q1_ch2_compare_out;
      next_pin_oe[3]  = 1'b1;
    end
    if (port9_alternate_enable[2] && code_of(2) == 2'b10) begin
      next_pin_out[2] = periph_out.timer_q1_ch1_compare_out;
      next_pin_oe[2]  = 1'b1;
    end
    if (port9_alternate_enable[0] && code_of(0) == 2'b10) begin
      next_pin_out[0] = periph_out.uart1_transmit_out;
      next_pin_oe[0]  = 1'b1;
    end
  end

  // Peripheral input routing; unselected inputs read zero.
  always_comb begin
    next_periph_in = '0;
    if (port9_alternate_enable[15] && port9_function_select[15]) begin
      next_periph_in.ext_interrupt_in_6 = pin_in[15];
    end
    if (port9_alternate_enable[14] && port9_function_select[14]) begin
      next_periph_in.ext_interrupt_in_5 = pin_in[14];
    end
    if (port9_alternate_enable[13] && code_of(13) == 2'b01) begin
      next_periph_in.ext_interrupt_in_4 = pin_in[13];
    end
    if (port9_alternate_enable[12] && port9_function_select[12]) begin
      next_periph_in.csi2_sck_in = pin_in[12];
    end
    if (port9_alternate_enable[10] && port9_function_select[10]) begin
      next_periph_in.csi2_si = pin_in[10];
    end
    if (port9_alternate_enable[9] && port9_function_select[9]) begin
      next_periph_in.csi1_sck_in = pin_in[9];
    end
    if (port9_alternate_enable[7] && code_of(7) == 2'b01) begin
      next_periph_in.csi1_si = pin_in[7];
    end
    if (port9_alternate_enable[7] && code_of(7) == 2'b10) begin
      next_periph_in.timer_p2_ch0_capture_in = pin_in[7];
    end
    if (port9_alternate_enable[6] && code_of(6) == 2'b10) begin
      next_periph_in.timer_p2_ch1_capture_in = pin_in[6];
    end
    if (port9_alternate_enable[5] && code_of(5) == 2'b01) begin
      next_periph_in.timer_q1_ch0_capture_in = pin_in[5];
    end
    if (port9_alternate_enable[4] && code_of(4) == 2'b01) begin
      next_periph_in.timer_q1_ch3_capture_in = pin_in[4];
    end
    if (port9_alternate_enable[3] && code_of(3) == 2'b01) begin
      next_periph_in.timer_q1_ch2_capture_in = pin_in[3];
    end
    if (port9_alternate_enable[2] && code_of(2) == 2'b01) begin
      next_periph_in.timer_q1_ch1_capture_in = pin_in[2];
    end
    if (port9_alternate_enable[1] && code_of(1) == 2'b01) begin
      next_periph_in.key_return_in_7 = pin_in[1];
    end
    if (port9_alternate_enable[1] && code_of(1) == 2'b10) begin
      next_periph_in.key_return_in_7  = pin_in[1];
      next_periph_in.uart1_receive_in = pin_in[1];
    end
    if (port9_alternate_enable[0] && code_of(0) == 2'b01) begin
      next_periph_in.key_return_in_6 = pin_in[0];
    end
  end

  // Registered pin side and peripheral side.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_out       <= 16'h0000;
      pin_oe        <= 16'h0000;
      pin_pullup_en <= 16'h0000;
      periph_in     <= '0;
    end else if (clk_en) begin
      pin_out       <= next_pin_out;
      pin_oe        <= next_pin_oe;
      pin_pullup_en <= port9_pullup_enable;
      periph_in     <= next_periph_in;
    end
  end

endmodule // port9_alt_function_select

// ===== board_model.sv
// Purpose: Board circuitry on the port 9 pins.
// Assumes: Bench chooses per pin whether the board drives it.
// Notes:   An undriven pin floats to a changing pattern unless pulled up.
`timescale 1ns/100ps
module board_model (
  // Clock
  input  wire logic        clk_sys,
  // Device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pullup_en,
  // Board side
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic [15:0]      pin_in
);
  logic [15:0] churn = 16'h5555;
  always_ff @(posedge clk_sys) begin
    churn <= ~churn;
  end
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & (pin_pullup_en | churn));
  end
endmodule // board_model

// ===== port9_alt_function_select_assertions.sv
// Purpose: Port checks of the port 9 mux block.
// Assumes: clk_en held high; registers shadowed from APB writes.
// Notes:   Shadow index is byte address bits 4:2.
`timescale 1ns/100ps
`include "port9_defs.svh"
module port9_checker
  import port9_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and peripherals
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pullup_en,
  input wire periph_out_t periph_out,
  input wire periph_in_t  periph_in
);
  logic [15:0] sh [0:5];
  logic [15:0] next_word;
  logic [15:0] lanes;
  wire  [2:0]  ix = paddr[4:2];
  wire         wr = psel & penable & pready & pwrite & !pslverr & (ix < 3'd6);
  always_comb begin
    lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    next_word = (pwdata[15:0] & lanes) | (sh[ix] & ~lanes);
    if (ix == 3'd4) begin
      next_word = next_word & `P9_FEXT_MASK;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        sh[i] <= 16'h0000;
      end
    end else if (wr) begin
      sh[ix] <= next_word;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  pullup_copy_a: assert property (pin_pullup_en == sh[5])
    else $error("pull-up enables differ from register");
  port_mode_a: assert property (((pin_oe ^ sh[1]) & ~sh[2]) == 0 &&
    ((pin_out ^ sh[0]) & sh[1] & ~sh[2]) == 0) else $error("port pin drive wrong");
  undef_zero_a: assert property ((pin_oe & sh[2] & ~sh[3] & ~sh[4]) == 0)
    else $error("pin driven with zero select code");
  in_pins_a: assert property ((pin_oe & sh[2] & 16'hC400) == 0)
    else $error("input-only pin driven");
  ext_int6_a: assert property (periph_in.ext_interrupt_in_6 ==
    (sh[2][15] & sh[3][15] & $past(pin_in[15]))) else $error("interrupt 6 routing wrong");
  clock_out_a: assert property (sh[2][13] && sh[4][13] && !sh[3][13] |->
    pin_oe[13] && pin_out[13] == $past(periph_out.programmable_clock_out))
    else $error("clock output wrong");
  sck2_a: assert property (sh[2][12] && sh[3][12] |-> pin_oe[12] == $past(periph_out.csi2_sck_oe)
    && periph_in.csi2_sck_in == $past(pin_in[12])) else $error("serial clock 2 wrong");
  tim7_a: assert property (sh[2][7] && sh[4][7] |-> pin_oe[7] == sh[3][7] && (sh[3][7] ?
    pin_out[7] == $past(periph_out.timer_p2_ch0_compare_out) :
    periph_in.timer_p2_ch0_capture_in == $past(pin_in[7])))
    else $error("pin 7 timer routing wrong");
  rx1_a: assert property (sh[2][1] && sh[4][1] && !sh[3][1] |-> !pin_oe[1] &&
    periph_in.uart1_receive_in == $past(pin_in[1]) &&
    periph_in.key_return_in_7 == $past(pin_in[1]))
    else $error("pin 1 receive routing wrong");
  cover property (sh[2][13] && pin_oe[13]);
  cover property (pready && pslverr);
  cover property (periph_in.uart1_receive_in);
endmodule // port9_checker
bind port9_alt_function_select port9_checker chk_u (.clk_sys, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
  .pin_pullup_en, .periph_out, .periph_in);

// ===== port9_alt_function_select_bench.sv
// Purpose: Self-checking bench of the port 9 mux block.
// Assumes: APB master per the hand-over contract; clk_en held high.
// Notes:   Each select table row is checked with peripherals at 1 and 0.
`timescale 1ns/100ps
`include "port9_defs.svh"
module port9_alt_function_select_bench
  import port9_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, rerr;
  logic [31:0] prdata, rdat;
  logic [15:0] pin_in, pin_out, pin_oe, pin_pullup_en, sck;
  logic [15:0] ext_val = 16'hFFFF;
  logic [15:0] ext_en = 16'hFFFF;
  periph_out_t periph_out = 14'h3FFF;
  periph_in_t  periph_in;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Per row: select, extension, drive enables, peripheral inputs.
  logic [15:0] cfg [4][4] = '{'{16'hFFFF, 16'h0000, 16'h1B00, 16'hFE7E},
    '{16'h0000, 16'h20FF, 16'h203D, 16'h0183}, '{16'hFFFF, 16'h20FF, 16'h1BC0, 16'h7C00},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000}};
  port9_alt_function_select dut_u (.clk_sys, .resetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .pin_in, .pin_out,
    .pin_oe, .pin_pullup_en, .periph_out, .periph_in);
  board_model board_u (.clk_sys, .pin_out, .pin_oe, .pin_pullup_en, .ext_val, .ext_en,
    .pin_in);
  always #4 clk_sys = ~clk_sys;
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rdat, exp);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), 32'h0000_0000);
    end
    xfer(1'b1, `P9_OFS_PULLUP, 32'hFFFF_A5C3, 4'hF);
    rd(`P9_OFS_PULLUP, 32'h0000_A5C3);
    xfer(1'b1, `P9_OFS_PULLUP, 32'h0000_3C00, 4'h2);
    xfer(1'b1, `P9_OFS_PULLUP, 32'h0000_0011, 4'h1);
    rd(`P9_OFS_PULLUP, 32'h0000_3C11);
    chk({16'h0000, pin_pullup_en}, 32'h0000_3C11);
    xfer(1'b1, `P9_OFS_PULLUP, 32'h0000_FFFF, 4'h3);
    ext_en <= 16'h0000;
    xfer(1'b1, `P9_OFS_LEVEL, 32'h0000_0000, 4'h3);
    rd(`P9_OFS_LEVEL, 32'h0000_FFFF);
    ext_en <= 16'hFFFF;
    xfer(1'b1, `P9_OFS_FEXT, 32'hFFFF_FFFF, 4'hF);
    rd(`P9_OFS_FEXT, 32'h0000_20FF);
    xfer(1'b1, 12'h01C, 32'h0000_FFFF, 4'hF);
    chk({31'h0, rerr}, 32'h0000_0001);
    rd(12'h01C, 32'h0000_0000);
    xfer(1'b1, `P9_OFS_LATCH, 32'h0000_00FF, 4'h3);
    xfer(1'b1, `P9_OFS_DIR, 32'h0000_0F0F, 4'h3);
    repeat (3) @(posedge clk_sys);
    chk({16'h0000, pin_oe}, 32'h0000_0F0F);
    chk({16'h0000, pin_out & pin_oe}, 32'h0000_000F);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, `P9_OFS_ALT, 32'h0000_0000, 4'h3);
      xfer(1'b1, `P9_OFS_FSEL, {16'h0000, cfg[c][0]}, 4'h3);
      xfer(1'b1, `P9_OFS_FEXT, {16'h0000, cfg[c][1]}, 4'h3);
      xfer(1'b1, `P9_OFS_ALT, 32'h0000_FFFF, 4'h3);
      for (int v = 1; v >= 0; v--) begin
        periph_out <= v ? 14'h3FFF : 14'h0000;
        sck = v ? 16'h0000 : 16'h1200;
        repeat (3) @(posedge clk_sys);
        chk({16'h0000, pin_oe}, {16'h0000, cfg[c][2] & ~sck});
        chk({16'h0000, pin_out & pin_oe}, v ? {16'h0000, cfg[c][2]} : 32'h0000_0000);
        chk({16'h0000, periph_in}, {16'h0000, cfg[c][3]});
      end
    end
    wrap_up();
  end
endmodule // port9_alt_function_select_bench
